/* pkg/awd_pkg.sv */
// package for the activity wakeup detector: register map, fields, types
// assumes a single 100 MHz clock domain and an 8-bit register port
package awd_pkg;

   localparam int          AWD_AXES        = 3;
   localparam int          AWD_SAMPLE_W    = 14;
   localparam int          AWD_VAL_W       = 6;

   // register map
   localparam logic [7:0]  AWD_OFS_MODE    = 8'h10;
   localparam logic [7:0]  AWD_OFS_THCTL   = 8'h13;
   localparam logic [7:0]  AWD_OFS_CFG     = 8'h14;
   localparam logic [7:0]  AWD_OFS_STATUS  = 8'h15;
   localparam logic [7:0]  AWD_OFS_MASK    = 8'h16;
   localparam logic [7:0]  AWD_OFS_AXSTAT  = 8'h17;

   // control register fields
   localparam int          AWD_THCTL_METHOD  = 7;
   localparam int          AWD_THCTL_COMBINE = 6;
   localparam int          AWD_MODE_PD_LO    = 4;
   localparam int          AWD_MODE_SNIFF    = 0;
   localparam int          AWD_CFG_CNTEN     = 3;

   // reset values
   localparam logic [7:0]  AWD_THCTL_RST   = 8'h00;
   localparam logic [7:0]  AWD_MODE_RST    = 8'h00;
   localparam logic [7:0]  AWD_CFG_RST     = 8'h00;
   localparam logic [7:0]  AWD_MASK_RST    = 8'h00;

   // status bits
   localparam int          AWD_ST_WAKE     = 0;
   localparam int          AWD_ST_SAMPLE   = 1;

   // shadow selector codes
   typedef enum logic [2:0] {
      AWD_SEL_NONE0 = 3'b000,
      AWD_SEL_TH_X  = 3'b001,
      AWD_SEL_TH_Y  = 3'b010,
      AWD_SEL_TH_Z  = 3'b011,
      AWD_SEL_NONE1 = 3'b100,
      AWD_SEL_CN_X  = 3'b101,
      AWD_SEL_CN_Y  = 3'b110,
      AWD_SEL_CN_Z  = 3'b111
   } awd_sel_e;

   typedef struct packed {
      logic [AWD_SAMPLE_W-1:0] x;
      logic [AWD_SAMPLE_W-1:0] y;
      logic [AWD_SAMPLE_W-1:0] z;
   } awd_sample_s;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } awd_bus_s;

endpackage : awd_pkg

/* verilog/awd_axis.sv */
// one axis of the detector: delta, threshold compare and event counter
// assumes samples arrive on sample_valid pulses in the same clock domain
`timescale 1ns/1ps
module awd_axis #(
   parameter int SW = 14,
   parameter int VW = 6
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          reset,
   // control
   input  wire logic          method,
   input  wire logic          sniff_entry,
   input  wire logic          cnt_en,
   input  wire logic [VW-1:0] threshold,
   input  wire logic [VW-1:0] count_load,
   // samples
   input  wire logic          sample_valid,
   input  wire logic [SW-1:0] sample,
   // result
   output logic               hit
);

   logic [SW-1:0] prev_reg;
   logic [SW-1:0] base_reg;
   logic          base_ok_reg;
   logic          have_prev_reg;
   logic [VW-1:0] cnt_reg;
   logic [VW-1:0] cnt_next;
   logic          hit_reg;
   logic          hit_next;

   ////////////////////////////////////////////////////////////////////
   wire [SW-1:0] ref_val  = method ? base_reg : prev_reg;
   wire          ref_ok   = method ? base_ok_reg : have_prev_reg;
   wire [SW-1:0] diff_ab  = sample - ref_val;
   wire [SW-1:0] diff_ba  = ref_val - sample;
   wire          neg      = $signed(sample) < $signed(ref_val);
   wire [SW-1:0] delta    = neg ? diff_ba : diff_ab;
   // clamp: a large delta must still read as over threshold
   wire          big      = |delta[SW-1:VW];
   // the sample that meets entry only primes the references
   wire          exceed   = sample_valid & ref_ok & ~sniff_entry
                          & (big | (delta[VW-1:0] > threshold));
   wire          cnt_full = cnt_reg >= count_load;
   assign cnt_next = (cnt_reg == {VW{1'b1}}) ? cnt_reg : cnt_reg + 1'b1;
   // without counting each exceedance reports at once
   assign hit_next = exceed & (~cnt_en | cnt_full);
   assign hit      = hit_reg;

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         prev_reg      <= '0;
         base_reg      <= '0;
         base_ok_reg   <= 1'b0;
         have_prev_reg <= 1'b0;
         cnt_reg       <= '0;
         hit_reg       <= 1'b0;
      end
      else
      begin
         hit_reg <= hit_next;
         if (sniff_entry)
         begin
            base_ok_reg   <= sample_valid;
            have_prev_reg <= sample_valid;
            cnt_reg       <= '0;
            // a sample on the entry edge is the first one and becomes the baseline
            if (sample_valid)
            begin
               prev_reg <= sample;
               base_reg <= sample;
            end
         end
         else if (sample_valid)
         begin
            prev_reg      <= sample;
            have_prev_reg <= 1'b1;
            if (!base_ok_reg)
            begin
               base_reg    <= sample;
               base_ok_reg <= 1'b1;
            end
            if (exceed && cnt_en)
               cnt_reg <= cnt_next;
         end
      end
   end

endmodule : awd_axis

/* verilog/awd_top.sv */
// activity wakeup detector: registers, shadow values, three axes, interrupt
// assumes register port and sample port are driven from clk's domain
`timescale 1ns/1ps
module awd_top
   import awd_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // register port
   input  wire awd_pkg::awd_bus_s bus,
   output logic [7:0]             rdata,
   // samples
   input  wire logic              sample_valid,
   input  wire awd_pkg::awd_sample_s sample,
   // wakeup
   output logic                   wakeup,
   output logic                   irq
);

   logic [7:0]            thctl_reg;
   logic [7:0]            mode_reg;
   logic [7:0]            cfg_reg;
   logic [7:0]            status_reg;
   logic [7:0]            status_next;
   logic [7:0]            mask_reg;
   logic [7:0]            rdata_reg;
   logic [7:0]            rdata_next;
   logic                  sniff_q_reg;
   logic                  wakeup_reg;
   logic                  irq_reg;
   logic [AWD_VAL_W-1:0]  th_reg  [AWD_AXES];
   logic [AWD_VAL_W-1:0]  cnt_reg [AWD_AXES];
   logic [AWD_AXES-1:0]   axis_hit;
   logic [AWD_SAMPLE_W-1:0] axis_sample [AWD_AXES];

   ////////////////////////////////////////////////////////////////////
   // decode
   wire wr_mode   = bus.wr & (bus.addr == AWD_OFS_MODE);
   wire wr_thctl  = bus.wr & (bus.addr == AWD_OFS_THCTL);
   wire wr_cfg    = bus.wr & (bus.addr == AWD_OFS_CFG);
   wire wr_status = bus.wr & (bus.addr == AWD_OFS_STATUS);
   wire wr_mask   = bus.wr & (bus.addr == AWD_OFS_MASK);
   wire [2:0] sel = cfg_reg[2:0];
   wire method    = thctl_reg[AWD_THCTL_METHOD];
   wire combine   = thctl_reg[AWD_THCTL_COMBINE];
   wire cnt_en    = cfg_reg[AWD_CFG_CNTEN];
   wire sniff_on  = mode_reg[AWD_MODE_SNIFF];
   wire sniff_entry = sniff_on & ~sniff_q_reg;
   wire [AWD_AXES-1:0] pd = mode_reg[AWD_MODE_PD_LO +: AWD_AXES];
   wire [AWD_AXES-1:0] active = ~pd;

   assign axis_sample[0] = sample.x;
   assign axis_sample[1] = sample.y;
   assign axis_sample[2] = sample.z;

   ////////////////////////////////////////////////////////////////////
   // combination: no active axis means no wakeup in either mode
   wire any_hit   = |(axis_hit & active);
   wire all_hit   = ((axis_hit | pd) == {AWD_AXES{1'b1}}) & (|active);
   wire wake_next = sniff_on & (combine ? all_hit : any_hit);

   // set wins over write-one-to-clear
   wire [7:0] ev = {6'h00, sample_valid & sniff_on, wake_next};
   assign status_next = (status_reg & ~(wr_status ? bus.wdata : 8'h00)) | ev;

   always_comb
   begin
      rdata_next = 8'h00;
      unique case (bus.addr)
         AWD_OFS_MODE:   rdata_next = mode_reg;
         AWD_OFS_THCTL:  rdata_next = thctl_reg;
         AWD_OFS_CFG:    rdata_next = cfg_reg;
         AWD_OFS_STATUS: rdata_next = status_reg;
         AWD_OFS_MASK:   rdata_next = mask_reg;
         AWD_OFS_AXSTAT: rdata_next = {5'h00, axis_hit};
         default:        rdata_next = 8'h00;
      endcase
      if (!bus.rd)
         rdata_next = 8'h00;
   end

   assign rdata  = rdata_reg;
   assign wakeup = wakeup_reg;
   assign irq    = irq_reg;

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         thctl_reg   <= AWD_THCTL_RST;
         mode_reg    <= AWD_MODE_RST;
         cfg_reg     <= AWD_CFG_RST;
         mask_reg    <= AWD_MASK_RST;
         status_reg  <= 8'h00;
         rdata_reg   <= 8'h00;
         sniff_q_reg <= 1'b0;
         wakeup_reg  <= 1'b0;
         irq_reg     <= 1'b0;
      end
      else
      begin
         if (wr_thctl)
            thctl_reg <= bus.wdata;
         if (wr_mode)
            mode_reg <= bus.wdata;
         if (wr_cfg)
            cfg_reg <= bus.wdata;
         if (wr_mask)
            mask_reg <= bus.wdata;
         status_reg  <= status_next;
         rdata_reg   <= rdata_next;
         sniff_q_reg <= sniff_on;
         wakeup_reg  <= wake_next;
         irq_reg     <= |(status_next & mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // shadow registers and axes
   genvar i;
   generate
      for (i = 0; i < AWD_AXES; i++)
      begin : g_axis
         wire [2:0] th_code = 3'(i + 1);
         wire [2:0] cn_code = 3'(i + 5);
         always_ff @(posedge clk or posedge reset)
         begin
            if (reset)
            begin
               th_reg[i]  <= '0;
               cnt_reg[i] <= '0;
            end
            else if (wr_thctl)
            begin
               if (sel == th_code)
                  th_reg[i] <= bus.wdata[AWD_VAL_W-1:0];
               if (sel == cn_code)
                  cnt_reg[i] <= bus.wdata[AWD_VAL_W-1:0];
            end
         end

         awd_axis #(
            .SW (AWD_SAMPLE_W),
            .VW (AWD_VAL_W)
         ) u_axis (
            .clk          (clk),
            .reset        (reset),
            .method       (method),
            .sniff_entry  (sniff_entry),
            .cnt_en       (cnt_en),
            .threshold    (th_reg[i]),
            .count_load   (cnt_reg[i]),
            .sample_valid (sample_valid & sniff_on),
            .sample       (axis_sample[i]),
            .hit          (axis_hit[i])
         );
      end
   endgenerate

endmodule : awd_top

/* bench/awd_asserts.sv */
// checker for awd_top: readback, wakeup cause and interrupt timing
// assumes only the top ports are visible; bound from tb_top
`timescale 1ns/1ps
module awd_asserts
   import awd_pkg::*;
(
   // clock and reset
   input wire logic                 clk,
   input wire logic                 reset,
   // watched ports
   input wire awd_pkg::awd_bus_s    bus,
   input wire logic [7:0]           rdata,
   input wire logic                 sample_valid,
   input wire awd_pkg::awd_sample_s sample,
   input wire logic                 wakeup,
   input wire logic                 irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic [7:0] ctl_reg, mode_reg, mask_reg;
   //////////////////////////////
   // shadow copies give readback a reference without peeking inside
   always_ff @(posedge clk or posedge reset)
      if (reset)
         {ctl_reg, mode_reg, mask_reg} <= '0;
      else if (bus.wr)
         case (bus.addr)
            AWD_OFS_THCTL: ctl_reg  <= bus.wdata;
            AWD_OFS_MODE:  mode_reg <= bus.wdata;
            AWD_OFS_MASK:  mask_reg <= bus.wdata;
            default:       ;
         endcase
   //////////////////////////////
   a_rdata_idle: assert property (!bus.rd |=> rdata == 8'h00)
      else $error("read data not zero");
   a_ctl_readback: assert property (bus.rd && bus.addr == AWD_OFS_THCTL |=> rdata == ctl_reg)
      else $error("control byte readback wrong");
   a_mode_readback: assert property (bus.rd && bus.addr == AWD_OFS_MODE |=> rdata == mode_reg)
      else $error("mode byte readback wrong");
   a_wake_cause: assert property (wakeup |-> $past(sample_valid, 2) && $past(mode_reg[0], 2))
      else $error("wakeup without sniff sample");
   a_sniff_off: assert property (sample_valid && !mode_reg[0] |=> !wakeup)
      else $error("wakeup while sniff off");
   a_all_down: assert property (sample_valid && mode_reg[6:4] == 3'b111 |=> !wakeup)
      else $error("wakeup with all axes down");
   a_irq_masked: assert property (mask_reg == 8'h00 && $past(mask_reg) == 8'h00 |-> !irq)
      else $error("irq with mask clear");
   a_wake_irq: assert property (wakeup && mask_reg[AWD_ST_WAKE] |-> irq)
      else $error("irq missing on wakeup");
endmodule : awd_asserts

/* bench/awd_host.sv */
// host model: drives the register port, one strobe per cycle
// assumes each task is entered just after a rising edge
`timescale 1ns/1ps
module awd_host
   import awd_pkg::*;
(
   // clock
   input  wire logic             clk,
   // register port
   output var awd_pkg::awd_bus_s bus
);
   initial bus = '0;
   // the next call replaces the strobe, so back to back needs no gap
   task automatic op(input logic w, r, input logic [7:0] a, d);
      bus <= '{wr: w, rd: r, addr: a, wdata: d};
      @(posedge clk);
   endtask : op
endmodule : awd_host

/* bench/tb_top.sv */
// bench for awd_top: register, sample and interrupt scenarios
// assumes awd_host drives the register port
`timescale 1ns/1ps
module tb_top;
   import awd_pkg::*;
   logic        clk = 1'b0, reset = 1'b1, sample_valid = 1'b0;
   awd_bus_s    bus;
   awd_sample_s sample = '0;
   logic [7:0]  rdata, rq[$], wq[$];
   logic        wakeup, irq, rd_d = 1'b0;
   logic [1:0]  sv_q = 2'b00;
   logic [31:0] seed = 32'h7b2d;
   logic [7:0]  vals[8] = '{8'h15, 8'h05, 8'h3f, 8'h3f, 8'h2a, 8'h02, 8'h00, 8'h00};
   int          failures = 0, checked = 0;
   always #5 clk = ~clk;
   awd_host host (.clk(clk), .bus(bus));
   awd_top DUT (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
      .sample_valid(sample_valid), .sample(sample), .wakeup(wakeup), .irq(irq));
   //////////////////////////////
   task automatic cmp(input logic [7:0] got, exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask : cmp
   task automatic close_out;
      $display("failures %0d checked %0d", failures, checked);
      if (failures == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   task automatic wr(input logic [7:0] a, d);
      sample_valid <= 1'b0;
      host.op(1'b1, 1'b0, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, e);
      sample_valid <= 1'b0;
      rq.push_back(e);
      host.op(1'b0, 1'b1, a, 8'h00);
   endtask : rd
   task automatic smp(input logic [13:0] x, y, z, input logic e);
      sample_valid <= 1'b1;
      sample <= '{x: x, y: y, z: z};
      wq.push_back({7'h00, e});
      host.op(1'b0, 1'b0, 8'h00, 8'h00);
   endtask : smp
   // idle cycle, then irq is looked at once settled
   task automatic irq_is(input logic e);
      sample_valid <= 1'b0;
      host.op(1'b0, 1'b0, 8'h00, 8'h00);
      #1;
      cmp({7'h00, irq}, {7'h00, e});
      @(posedge clk);
   endtask : irq_is
   //////////////////////////////
   // read data stand one cycle after the strobe; wakeup passes the axis
   // register first, so it stands two cycles after its sample
   always @(posedge clk)
   begin
      if (rd_d)
         cmp(rdata, rq.pop_front());
      if (sv_q[1])
         cmp({7'h00, wakeup}, wq.pop_front());
      rd_d <= bus.rd;
      sv_q <= {sv_q[0], sample_valid};
   end
   initial
   begin
      #20000;
      failures++;
      close_out();
   end
   initial
   begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      rd(AWD_OFS_THCTL, 8'h00);
      rd(8'h2a, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         smp(seed[13:0], seed[27:14], seed[31:18], 1'b0);
      end
      for (int s = 0; s < 8; s++)
      begin
         wr(AWD_OFS_CFG, 8'(s));
         wr(AWD_OFS_THCTL, vals[s]);
         rd(AWD_OFS_THCTL, vals[s]);
      end
      wr(AWD_OFS_CFG, 8'h00);
      wr(AWD_OFS_MODE, 8'h01);
      smp(0, 0, 0, 0);
      smp(5, 0, 0, 0);
      smp(11, 0, 0, 1);
      smp(11, 0, 0, 0);
      smp(11, 100, 0, 1);
      rd(AWD_OFS_STATUS, 8'h03);
      wr(AWD_OFS_MASK, 8'h01);
      irq_is(1'b1);
      wr(AWD_OFS_MASK, 8'h00);
      wr(8'h00, 8'h00);
      irq_is(1'b0);
      wr(AWD_OFS_MASK, 8'h01);
      wr(AWD_OFS_STATUS, 8'h03);
      irq_is(1'b0);
      rd(AWD_OFS_STATUS, 8'h00);
      wr(AWD_OFS_MODE, 8'h00);
      wr(AWD_OFS_THCTL, 8'h80);
      rd(AWD_OFS_THCTL, 8'h80);
      wr(AWD_OFS_MODE, 8'h01);
      smp(0, 0, 0, 0);
      smp(3, 0, 0, 0);
      smp(6, 0, 0, 1);
      smp(6, 0, 0, 1);
      wr(AWD_OFS_THCTL, 8'hc0);
      smp(6, 0, 0, 0);
      smp(6, 100, 100, 1);
      wr(AWD_OFS_THCTL, 8'h00);
      wr(AWD_OFS_MODE, 8'h71);
      smp(100, 0, 0, 0);
      rd(AWD_OFS_MODE, 8'h71);
      // and with x powered down: y and z alone decide
      wr(AWD_OFS_THCTL, 8'h40);
      wr(AWD_OFS_MODE, 8'h11);
      smp(100, 100, 100, 1);
      rd(AWD_OFS_AXSTAT, 8'h06);
      smp(100, 0, 100, 0);
      for (int k = 0; k < 2; k++)
      begin
         wr(AWD_OFS_MODE, 8'h00);
         wr(AWD_OFS_CFG, 8'h0d);
         wr(AWD_OFS_THCTL, 8'h02);
         wr(AWD_OFS_MODE, 8'h01);
         smp(0, 0, 0, 0);
         smp(10, 0, 0, 0);
         smp(0, 0, 0, 0);
         smp(10, 0, 0, 1);
         smp(0, 0, 0, 1);
      end
      wr(8'h00, 8'h00);
      wr(8'h00, 8'h00);
      wr(8'h00, 8'h00);
      close_out();
   end
endmodule : tb_top

bind awd_top awd_asserts u_chk (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
   .sample_valid(sample_valid), .sample(sample), .wakeup(wakeup), .irq(irq));
